//--- rtl/extif_pkg.sv
// constants for the external interrupt flag and entry timing block
`default_nettype none
package extif_pkg;
   localparam int NIRQ = 5;
   localparam int NWKP = 8;
   localparam int AW   = 16;
   localparam logic [7:0] OFS_PFA   = 8'h00;
   localparam logic [7:0] OFS_PFB   = 8'h04;
   localparam logic [7:0] OFS_WKF   = 8'h08;
   localparam logic [7:0] OFS_EDGE  = 8'h0C;
   localparam logic [7:0] OFS_RQF   = 8'h10;
   localparam logic [7:0] OFS_WFL   = 8'h14;
   localparam logic [7:0] OFS_IEN   = 8'h18;
   localparam logic [7:0] OFS_CCR   = 8'h1C;
   localparam logic [7:0] OFS_EVST  = 8'h20;
   localparam logic [7:0] OFS_EVMSK = 8'h24;
   localparam logic [7:0] OFS_STATE = 8'h28;
   localparam int CCR_I   = 7;
   localparam int EV_ENTRY = 0;
   localparam int EV_BLOCK = 1;
   localparam logic [3:0] WAIT_MAX  = 4'hD;
   localparam logic [3:0] STACK_ST  = 4'h4;
   localparam logic [3:0] VECT_ST   = 4'h2;
   localparam logic [3:0] FETCH_ST  = 4'h4;
   localparam logic [3:0] PROC_ST   = 4'h4;
   localparam logic [3:0] CCR_SLOT  = 4'h2;
   localparam logic [4:0] VEC_EXT_REQUEST_PIN0  = 5'h04;
   localparam logic [4:0] VEC_WAKE  = 5'h09;
   localparam logic [AW-1:0] WORD_B = 16'h0002;
   typedef enum logic [2:0] {
      EXTIF_IDLE  = 3'b000,
      EXTIF_WAIT  = 3'b001,
      EXTIF_STACK = 3'b011,
      EXTIF_VECT  = 3'b010,
      EXTIF_FETCH = 3'b110,
      EXTIF_PROC  = 3'b111
   } extif_state_t;
endpackage : extif_pkg
`default_nettype wire

//--- rtl/extif_top.sv
// external interrupt flags, apb registers and exception entry sequencer
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
module extif_top
   import extif_pkg::*;
(
   input  wire logic            CLK,
   input  wire logic            SYS_RST,
   input  wire logic            PSEL,
   input  wire logic            PENABLE,
   input  wire logic            PWRITE,
   input  wire logic [7:0]      PADDR,
   input  wire logic [31:0]     PWDATA,
   output logic      [31:0]     PRDATA,
   output logic                 PREADY,
   output logic                 PSLVERR,
   input  wire logic [NIRQ-1:0] EXT_REQUEST_PIN,
   input  wire logic [NWKP-1:0] WAKE_PIN,
   input  wire logic            INSTR_END,
   input  wire logic [AW-1:0]   PC_IN,
   input  wire logic [AW-1:0]   STACK_POINTER,
   input  wire logic [7:0]      CCR_IN,
   input  wire logic            RETURN_FROM_EXCEPTION,
   input  wire logic [AW-1:0]   RTE_CCR_WORD,
   input  wire logic [AW-1:0]   BUS_RDATA,
   output logic      [AW-1:0]   BUS_ADDR,
   output logic      [AW-1:0]   BUS_WDATA,
   output logic                 BUS_WR,
   output logic                 BUS_RD,
   output logic      [4:0]      VECTOR,
   output logic                 HANDLER_START,
   output logic                 IRQ
);
   function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] a);
      word_addr = {a[AW-1:1], 1'b0};
   endfunction : word_addr

   // pin synchronisers and previous samples
   logic [NIRQ-1:0] irq_s1_q, irq_s2_q, irq_s3_q;
   logic [NWKP-1:0] wkp_s1_q, wkp_s2_q, wkp_s3_q;
   always_ff @(posedge CLK) begin
      irq_s1_q <= EXT_REQUEST_PIN;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      wkp_s1_q <= WAKE_PIN;
      wkp_s2_q <= wkp_s1_q;
      wkp_s3_q <= wkp_s2_q;
   end

   // registers
   logic [4:0]      pfa_q, pfb_q, edge_q, rqf_q;
   logic [NWKP-1:0] wkf_q, wfl_q;
   logic [5:0]      ien_q;
   logic            imask_q, guard_q;
   logic [1:0]      evst_q, evmsk_q;
   logic [NIRQ-1:0] pf_prev_q;
   logic [NWKP-1:0] wk_prev_q;

   wire xfer    = PSEL && PENABLE;
   wire wr      = xfer && PWRITE;
   wire hit_pfa = PADDR == OFS_PFA;
   wire hit_pfb = PADDR == OFS_PFB;
   wire hit_wkf = PADDR == OFS_WKF;
   wire hit_edg = PADDR == OFS_EDGE;
   wire hit_rqf = PADDR == OFS_RQF;
   wire hit_wfl = PADDR == OFS_WFL;
   wire hit_ien = PADDR == OFS_IEN;
   wire hit_ccr = PADDR == OFS_CCR;
   wire hit_evs = PADDR == OFS_EVST;
   wire hit_evm = PADDR == OFS_EVMSK;
   wire hit_st  = PADDR == OFS_STATE;
   wire mapped  = hit_pfa | hit_pfb | hit_wkf | hit_edg | hit_rqf | hit_wfl
                | hit_ien | hit_ccr | hit_evs | hit_evm | hit_st;
   wire pf_acc  = xfer && mapped && (hit_pfa | hit_pfb | hit_wkf);
   wire clr_try = wr && (hit_rqf | hit_wfl);
   wire clr_ok  = clr_try && !guard_q;

   // pin function per request input: a holds inputs 1..3, b holds 0 and 4
   wire [NIRQ-1:0] pf = {pfb_q[4], pfa_q[3:1], pfb_q[0]};
   wire [NIRQ-1:0] pin_lo = ~irq_s2_q;
   wire [NIRQ-1:0] fall = irq_s3_q & ~irq_s2_q;
   wire [NIRQ-1:0] rise = ~irq_s3_q & irq_s2_q;
   wire [NIRQ-1:0] real_e = pf & ((fall & ~edge_q) | (rise & edge_q));
   wire [NIRQ-1:0] sp_on  = pf & ~pf_prev_q & pin_lo & ~edge_q;
   wire [NIRQ-1:0] sp_off = ~pf & pf_prev_q & pin_lo & edge_q;
   wire [NIRQ-1:0] rq_set = real_e | sp_on | sp_off;
   wire [NWKP-1:0] w_fall = wkf_q & wkp_s3_q & ~wkp_s2_q;
   wire [NWKP-1:0] w_sp   = wkf_q & ~wk_prev_q & ~wkp_s2_q;
   wire [NWKP-1:0] wf_set = w_fall | w_sp;

   wire [NIRQ-1:0] rq_clr = (clr_ok && hit_rqf) ? ~PWDATA[NIRQ-1:0] : '0;
   wire [NWKP-1:0] wf_clr = (clr_ok && hit_wfl) ? ~PWDATA[NWKP-1:0] : '0;
   wire [NIRQ-1:0] rq_d = rq_set | (rqf_q & ~rq_clr);
   // wakeup flags are never touched by acceptance
   wire [NWKP-1:0] wf_d = wf_set | (wfl_q & ~wf_clr);

   // pending request, lowest numbered input first, wakeup last
   wire [NIRQ-1:0] rq_pend = rqf_q & ien_q[NIRQ-1:0];
   wire            wk_pend = (|wfl_q) && ien_q[NIRQ];
   wire            req = ((|rq_pend) || wk_pend) && !imask_q;
   logic [4:0] vec_sel;
   always_comb begin
      vec_sel = VEC_WAKE;
      for (int i = NIRQ - 1; i >= 0; i--) begin
         if (rq_pend[i]) begin
            vec_sel = VEC_EXT_REQUEST_PIN0 + 5'(i);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pf_prev_q <= '0;
         wk_prev_q <= '0;
      end else begin
         pf_prev_q <= pf;
         wk_prev_q <= wkf_q;
      end
   end

   // sequencer
   extif_state_t st_q, st_d;
   logic [3:0]    cnt_q, cnt_d;
   logic [AW-1:0] hnd_q;
   wire last_wait = INSTR_END || (cnt_q == WAIT_MAX - 4'h1);
   wire go_idle   = (st_q == EXTIF_IDLE) && req && INSTR_END;
   wire go_wait   = (st_q == EXTIF_WAIT) && last_wait;
   wire accept    = go_idle || go_wait;
   wire end_stack = (st_q == EXTIF_STACK) && (cnt_q == STACK_ST - 4'h1);
   wire end_vect  = (st_q == EXTIF_VECT) && (cnt_q == VECT_ST - 4'h1);
   wire end_fetch = (st_q == EXTIF_FETCH) && (cnt_q == FETCH_ST - 4'h1);
   wire end_proc  = (st_q == EXTIF_PROC) && (cnt_q == PROC_ST - 4'h1);

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q + 4'h1;
      unique case (st_q)
         EXTIF_IDLE: begin
            cnt_d = 4'h0;
            if (go_idle) begin
               st_d = EXTIF_STACK;
            end else if (req) begin
               st_d  = EXTIF_WAIT;
               cnt_d = 4'h1;
            end
         end
         EXTIF_WAIT: begin
            if (go_wait) begin
               st_d  = EXTIF_STACK;
               cnt_d = 4'h0;
            end
         end
         EXTIF_STACK: begin
            if (end_stack) begin
               st_d  = EXTIF_VECT;
               cnt_d = 4'h0;
            end
         end
         EXTIF_VECT: begin
            if (end_vect) begin
               st_d  = EXTIF_FETCH;
               cnt_d = 4'h0;
            end
         end
         EXTIF_FETCH: begin
            if (end_fetch) begin
               st_d  = EXTIF_PROC;
               cnt_d = 4'h0;
            end
         end
         EXTIF_PROC: begin
            if (end_proc) begin
               st_d  = EXTIF_IDLE;
               cnt_d = 4'h0;
            end
         end
         default: begin
            st_d  = EXTIF_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   // stack and fetch accesses, all word sized on even addresses
   wire stk_pc  = (st_q == EXTIF_STACK) && (cnt_q == 4'h0);
   wire stk_ccr = (st_q == EXTIF_STACK) && (cnt_q == CCR_SLOT);
   wire vec_rd  = (st_q == EXTIF_VECT) && (cnt_q == 4'h0);
   wire fet_rd  = (st_q == EXTIF_FETCH) && (cnt_q == 4'h0);
   wire [AW-1:0] sp_pc  = word_addr(STACK_POINTER - WORD_B);
   wire [AW-1:0] sp_ccr = word_addr(STACK_POINTER - WORD_B - WORD_B);
   wire [AW-1:0] vaddr  = word_addr({10'h000, VECTOR, 1'b0});

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         st_q          <= EXTIF_IDLE;
         cnt_q         <= 4'h0;
         VECTOR        <= VEC_WAKE;
         hnd_q         <= '0;
         BUS_ADDR      <= '0;
         BUS_WDATA     <= '0;
         BUS_WR        <= 1'b0;
         BUS_RD        <= 1'b0;
         HANDLER_START <= 1'b0;
      end else begin
         st_q          <= st_d;
         cnt_q         <= cnt_d;
         HANDLER_START <= end_proc;
         BUS_WR        <= stk_pc || stk_ccr;
         BUS_RD        <= vec_rd || fet_rd;
         if (accept) begin
            VECTOR <= vec_sel;
         end
         if (stk_pc) begin
            BUS_ADDR  <= sp_pc;
            BUS_WDATA <= PC_IN;
         end else if (stk_ccr) begin
            BUS_ADDR  <= sp_ccr;
            BUS_WDATA <= {CCR_IN, CCR_IN};
         end else if (vec_rd) begin
            BUS_ADDR <= vaddr;
         end else if (fet_rd) begin
            BUS_ADDR <= word_addr(hnd_q);
         end
         if (end_vect) begin
            hnd_q <= BUS_RDATA;
         end
      end
   end

   // register writes; hardware sets win over software clears
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pfa_q   <= '0;
         pfb_q   <= '0;
         wkf_q   <= '0;
         edge_q  <= '0;
         rqf_q   <= '0;
         wfl_q   <= '0;
         ien_q   <= '0;
         imask_q <= 1'b0;
         guard_q <= 1'b0;
         evst_q  <= '0;
         evmsk_q <= '0;
      end else begin
         rqf_q <= rq_d;
         wfl_q <= wf_d;
         if (wr && hit_pfa) pfa_q <= PWDATA[4:0];
         if (wr && hit_pfb) pfb_q <= PWDATA[4:0];
         if (wr && hit_wkf) wkf_q <= PWDATA[NWKP-1:0];
         if (wr && hit_edg) edge_q <= PWDATA[4:0];
         if (wr && hit_ien) ien_q <= PWDATA[5:0];
         if (wr && hit_evm) evmsk_q <= PWDATA[1:0];
         if (pf_acc) begin
            guard_q <= 1'b1;
         end else if (xfer || INSTR_END) begin
            guard_q <= 1'b0;
         end
         if (accept) begin
            imask_q <= 1'b1;
         end else if (RETURN_FROM_EXCEPTION) begin
            imask_q <= RTE_CCR_WORD[AW-8+CCR_I];
         end else if (wr && hit_ccr) begin
            imask_q <= PWDATA[CCR_I];
         end
         evst_q[EV_ENTRY] <= end_proc
                          || (evst_q[EV_ENTRY] && !(wr && hit_evs && PWDATA[EV_ENTRY]));
         evst_q[EV_BLOCK] <= (clr_try && guard_q)
                          || (evst_q[EV_BLOCK] && !(wr && hit_evs && PWDATA[EV_BLOCK]));
      end
   end

   // apb read mux, zero wait states
   logic [31:0] rd;
   always_comb begin
      rd = '0;
      if (hit_pfa) rd[4:0] = pfa_q;
      if (hit_pfb) rd[4:0] = pfb_q;
      if (hit_wkf) rd[NWKP-1:0] = wkf_q;
      if (hit_edg) rd[4:0] = edge_q;
      if (hit_rqf) rd[4:0] = rqf_q;
      if (hit_wfl) rd[NWKP-1:0] = wfl_q;
      if (hit_ien) rd[5:0] = ien_q;
      if (hit_ccr) rd[CCR_I] = imask_q;
      if (hit_evs) rd[1:0] = evst_q;
      if (hit_evm) rd[1:0] = evmsk_q;
      if (hit_st) rd[6:0] = {cnt_q, st_q};
   end
   assign PRDATA  = rd;
   assign PREADY  = 1'b1;
   assign PSLVERR = xfer && !mapped;
   assign IRQ     = |(evst_q & evmsk_q);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   property p_wait_bound;
      (st_q == EXTIF_IDLE && req && !INSTR_END) |-> ##[2:13] (st_q == EXTIF_STACK);
   endproperty
   a_wait_bound: assert property (p_wait_bound) else $error("wait too long");
   property p_entry_len;
      (st_q != EXTIF_STACK) ##1 (st_q == EXTIF_STACK) |-> ##14 HANDLER_START;
   endproperty
   a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
   property p_stack_len;
      $rose(st_q == EXTIF_STACK) |-> (st_q == EXTIF_STACK)[*4] ##1 (st_q == EXTIF_VECT);
   endproperty
   a_stack_len: assert property (p_stack_len) else $error("stack phase length");
   property p_even;
      (BUS_WR || BUS_RD) |-> !BUS_ADDR[0];
   endproperty
   a_even: assert property (p_even) else $error("odd word address");
   property p_ccr_word;
      $past(stk_ccr) |-> BUS_WR && BUS_WDATA[15:8] == BUS_WDATA[7:0];
   endproperty
   a_ccr_word: assert property (p_ccr_word) else $error("ccr not both bytes");
   property p_sp_on;
      sp_on[0] |=> rqf_q[0];
   endproperty
   a_sp_on: assert property (p_sp_on) else $error("function on flag missed");
   property p_sp_off;
      sp_off[4] |=> rqf_q[4];
   endproperty
   a_sp_off: assert property (p_sp_off) else $error("function off flag missed");
   property p_wake;
      w_sp[7] |=> wfl_q[7];
   endproperty
   a_wake: assert property (p_wake) else $error("wakeup flag missed");
   property p_guard;
      (clr_try && guard_q && rqf_q[1]) |=> rqf_q[1];
   endproperty
   a_guard: assert property (p_guard) else $error("guarded clear took effect");
   property p_wk_keep;
      (wfl_q[2] && !clr_ok) |=> wfl_q[2];
   endproperty
   a_wk_keep: assert property (p_wk_keep) else $error("wakeup flag lost");
   property p_accept_mask;
      accept |=> imask_q;
   endproperty
   a_accept_mask: assert property (p_accept_mask) else $error("mask not set");
endmodule : extif_top
`default_nettype wire

//--- test/extif_cpu_model.sv
// far-side model: cpu instruction ends and memory answers
`default_nettype none
module extif_cpu_model
   import extif_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          SYS_RST,
   input  wire logic          ARM,
   input  wire logic [3:0]    ILEN,
   input  wire logic [AW-1:0] BUS_ADDR,
   input  wire logic          BUS_RD,
   output logic      [AW-1:0] BUS_RDATA,
   output logic               INSTR_END
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]    cnt_q;
   logic [AW-1:0] junk_q;
   // an instruction lasts ILEN states while armed
   assign INSTR_END = ARM && (cnt_q + 4'h1 == ILEN);
   // handler address is odd on purpose; an idle bus shows a moving pattern
   assign BUS_RDATA = BUS_RD ? (BUS_ADDR ^ 16'h4001) : junk_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         junk_q <= 16'h5A5A;
      end else begin
         junk_q <= ~junk_q + 16'h1357;
      end
      if (SYS_RST || !ARM || INSTR_END) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : extif_cpu_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the external interrupt flag and entry block
`default_nettype none
module tb
   import extif_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic            CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INSTR_END, ARM;
   logic            RETURN_FROM_EXCEPTION, BUS_WR, BUS_RD, HANDLER_START, IRQ, se;
   logic [3:0]      ILEN;
   logic [4:0]      VECTOR, vec;
   logic [7:0]      PADDR, CCR_IN, fa, cc;
   logic [31:0]     PWDATA, PRDATA, rd;
   logic [NIRQ-1:0] EXT_REQUEST_PIN;
   logic [NWKP-1:0] WAKE_PIN;
   logic [AW-1:0]   PC_IN, STACK_POINTER, RTE_CCR_WORD, BUS_RDATA, BUS_ADDR, BUS_WDATA;
   logic [AW-1:0]   pc, sp, ea [4], a_q [$], d_q [$];
   int              err_count, samples_checked, cyc, i, ilen, w, n, t_q [$];
   extif_top dut_u (
      .CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
      .EXT_REQUEST_PIN, .WAKE_PIN, .INSTR_END, .PC_IN, .STACK_POINTER, .CCR_IN,
      .RETURN_FROM_EXCEPTION, .RTE_CCR_WORD, .BUS_RDATA, .BUS_ADDR, .BUS_WDATA, .BUS_WR,
      .BUS_RD, .VECTOR, .HANDLER_START, .IRQ);
   extif_cpu_model cpu_u (
      .CLK, .SYS_RST, .ARM, .ILEN, .BUS_ADDR, .BUS_RD, .BUS_RDATA, .INSTR_END);
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      rd = PRDATA;
      se = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask : rdc
   // function change on a low pin, clear right after it, then clear after a spacer access
   task automatic spur(input logic [7:0] f, input logic [31:0] fv, input logic [7:0] g,
                       input logic [31:0] gv);
      apb(1'b1, f, fv);
      apb(1'b1, g, 32'h0);
      rdc(g, gv, "flag kept");
      rdc(OFS_EVST, 32'h2, "blocked event");
      chk(IRQ, 1'b1, "irq on block");
      apb(1'b1, OFS_EVST, 32'h2);
      chk(IRQ, 1'b0, "irq after w1c");
      apb(1'b1, g, 32'h0);
      rdc(g, 32'h0, "flag cleared");
   endtask : spur
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         $display("MISMATCH t=%0t timeout", $time);
         wrap_up();
      end
   end
   initial begin
      void'($urandom(98312));
      {SYS_RST, PSEL, PENABLE, PWRITE, ARM, RETURN_FROM_EXCEPTION} = 6'h20;
      {PADDR, PWDATA, ILEN, CCR_IN, PC_IN, STACK_POINTER, RTE_CCR_WORD} = '0;
      EXT_REQUEST_PIN = '1;
      WAKE_PIN = '1;
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      for (int a = 0; a < 12; a++) begin
         rdc(8'(4 * a), 32'h0, "reset value");
         chk(32'(se), 32'(a == 11), "slave error");
      end
      apb(1'b1, OFS_EVMSK, 32'h3);
      apb(1'b1, OFS_CCR, 32'h80);
      for (int r = 0; r < NIRQ; r++) begin
         fa = (r == 0 || r == 4) ? OFS_PFB : OFS_PFA;
         for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFS_EDGE, s << r);
            apb(1'b1, fa, 1 << r);
            apb(1'b1, fa, s << r);
            EXT_REQUEST_PIN[r] <= 1'b0;
            repeat (3) @(posedge CLK);
            rdc(OFS_RQF, 32'h0, "no flag");
            spur(fa, (1 - s) << r, OFS_RQF, 1 << r);
            EXT_REQUEST_PIN[r] <= 1'b1;
            repeat (3) @(posedge CLK);
         end
      end
      apb(1'b1, OFS_PFA, 32'h4);
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, OFS_EDGE, s << 2);
         EXT_REQUEST_PIN[2] <= 1'(s);
         repeat (4) @(posedge CLK);
         rdc(OFS_RQF, 32'h4, "real edge");
         apb(1'b1, OFS_RQF, 32'h0);
      end
      apb(1'b1, OFS_PFA, 32'h0);
      apb(1'b1, OFS_EDGE, 32'h0);
      for (int k = 0; k < NWKP; k++) begin
         WAKE_PIN[k] <= 1'b0;
         repeat (3) @(posedge CLK);
         spur(OFS_WKF, 1 << k, OFS_WFL, 1 << k);
         apb(1'b1, OFS_WKF, 32'h0);
         WAKE_PIN[k] <= 1'b1;
      end
      // pass 0 waits on a random instruction, 1 is forced out, 2 is taken at once
      for (int j = 0; j < 3; j++) begin
         i = (j == 1) ? $urandom_range(7, 0) : $urandom_range(4, 0);
         ilen = (j == 0) ? $urandom_range(12, 1) : (j == 1) ? 15 : 1;
         w = (j == 2) ? 1 : (ilen > 12) ? 13 : ilen + 1;
         pc = 16'($urandom);
         sp = 16'($urandom) & 16'hFFFE;
         cc = 8'($urandom) & 8'h7F;
         vec = (j == 1) ? VEC_WAKE : VEC_EXT_REQUEST_PIN0 + 5'(i);
         fa = (j == 1) ? OFS_WKF : (i == 0 || i == 4) ? OFS_PFB : OFS_PFA;
         PC_IN <= pc;
         STACK_POINTER <= sp;
         CCR_IN <= cc;
         ILEN <= 4'(ilen);
         apb(1'b1, OFS_CCR, 32'h80);
         apb(1'b1, OFS_IEN, (j == 1) ? 32'h20 : 1 << i);
         if (j == 1) WAKE_PIN[i] <= 1'b0;
         else EXT_REQUEST_PIN[i] <= 1'b0;
         repeat (3) @(posedge CLK);
         apb(1'b1, fa, 1 << i);
         ARM <= 1'(j == 2);
         apb(1'b1, OFS_CCR, 32'h0);
         ARM <= 1'b1;
         n = 1;
         t_q.delete();
         a_q.delete();
         d_q.delete();
         while (HANDLER_START !== 1'b1 && n < 40) begin
            @(posedge CLK);
            n++;
            if (BUS_WR === 1'b1 || BUS_RD === 1'b1) begin
               t_q.push_back(n);
               a_q.push_back(BUS_ADDR);
               d_q.push_back(BUS_WDATA);
            end
         end
         ARM <= 1'b0;
         ea[0] = (sp - 16'h2) & 16'hFFFE;
         ea[1] = (sp - 16'h4) & 16'hFFFE;
         ea[2] = {10'h0, vec, 1'b0};
         ea[3] = (ea[2] ^ 16'h4001) & 16'hFFFE;
         chk(n, w + 15, "entry states");
         chk(t_q.size(), 4, "bus ops");
         for (int k = 0; k < 4; k++) begin
            chk(t_q[k], w + 2 + 2 * k, "op cycle");
            chk(a_q[k], ea[k], "op addr");
         end
         chk(d_q[0], pc, "pc word");
         chk(d_q[1], {cc, cc}, "ccr word");
         chk(VECTOR, vec, "vector");
         rdc(OFS_CCR, 32'h80, "mask on entry");
         rdc(OFS_EVST, 32'h1, "entry event");
         chk(IRQ, 1'b1, "irq on entry");
         if (j == 1) rdc(OFS_WFL, 1 << i, "wake flag kept");
         apb(1'b1, OFS_EVMSK, 32'h0);
         chk(IRQ, 1'b0, "irq masked");
         apb(1'b1, OFS_EVMSK, 32'h3);
         EXT_REQUEST_PIN <= '1;
         WAKE_PIN <= '1;
         apb(1'b1, fa, 32'h0);
         apb(1'b1, OFS_IEN, 32'h0);
         apb(1'b1, OFS_RQF, 32'h0);
         apb(1'b1, OFS_WFL, 32'h0);
         apb(1'b1, OFS_EVST, 32'h3);
         chk(IRQ, 1'b0, "irq cleared");
         RTE_CCR_WORD <= 16'h00FF;
         RETURN_FROM_EXCEPTION <= 1'b1;
         @(posedge CLK);
         RETURN_FROM_EXCEPTION <= 1'b0;
         rdc(OFS_CCR, 32'h0, "mask after return");
      end
      wrap_up();
   end
endmodule : tb
`default_nettype wire
